/* hw/abwr_autobaud_wakeup_rx.sv */
// Added by the designer: the address map and the Wishbone interface to the registers.
`default_nettype none
module abwr_autobaud_wakeup_rx
  import abwr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,

  // wishbone slave
  input wire abwr_wb_req_t wb_req,
  output abwr_wb_rsp_t wb_rsp,

  // serial line and processor mode
  input wire logic receive_data_line,
  input wire logic sleep_mode,

  // to the receiver and interrupt logic
  output logic receive_interrupt_flag,
  output logic receiver_hold
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [8:0] abwr_tick_mask(
    input logic sixteen,
    input logic high_speed
  );
    logic [1:0] sel;
    sel = {sixteen, high_speed};
    unique case (sel)
      2'h0: abwr_tick_mask = ABWR_MASK_SLOW;
      2'h3: abwr_tick_mask = ABWR_MASK_FAST;
      default: abwr_tick_mask = ABWR_MASK_MID;
    endcase
  endfunction

  function automatic logic abwr_hit(
    input logic [7:0] adr,
    input logic [7:0] reg_adr
  );
    abwr_hit = (adr[7:2] == reg_adr[7:2]);
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  abwr_state_t q;
  abwr_state_t next_q;

  logic next_line;
  logic rise;
  logic fall;
  logic tick;
  logic access;
  logic commit;
  logic wr;
  logic rd;
  logic async_mode;
  logic cal_done;
  logic wake_fall;
  logic [7:0] rdata;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_q = q;

    // line filter: first stage feeds only the second
    next_q.line_sync = {q.line_sync[1:0], receive_data_line};
    if (q.line_sync[1] == q.line_sync[2]) begin
      next_line = q.line_sync[2];
    end else begin
      next_line = q.line;
    end
    next_q.line = next_line;
    rise = next_line & ~q.line;
    fall = ~next_line & q.line;

    // calibration clock divider, stopped in sleep
    tick = 1'b0;
    if (!sleep_mode) begin
      next_q.prescale = 9'(q.prescale + 9'h001);
      tick = ((q.prescale & abwr_tick_mask(q.ctrl[ABWR_CTRL_SIXTEEN],
        q.ctrl[ABWR_CTRL_HIGH_SPEED])) == 9'h000);
    end

    // bus handshake: ack one cycle after request, effect on ack edge
    access = wb_req.cyc & wb_req.stb;
    next_q.rsp.ack = access & ~q.rsp.ack;
    commit = access & q.rsp.ack;
    wr = commit & wb_req.we & wb_req.sel[0];
    rd = commit & ~wb_req.we;

    rdata = 8'h00;
    if (abwr_hit(wb_req.adr, ABWR_ADR_CTRL)) begin
      rdata = q.ctrl;
    end else if (abwr_hit(wb_req.adr, ABWR_ADR_DIV_LO)) begin
      rdata = q.divisor[7:0];
    end else if (abwr_hit(wb_req.adr, ABWR_ADR_DIV_HI)) begin
      rdata = q.divisor[15:8];
    end else if (abwr_hit(wb_req.adr, ABWR_ADR_RX_DATA)) begin
      rdata = ABWR_RX_DATA_IDLE;
    end else if (abwr_hit(wb_req.adr, ABWR_ADR_STATUS)) begin
      rdata[ABWR_STAT_FLAG] = q.flag;
      rdata[ABWR_STAT_BUSY] = (q.cal != AB_IDLE);
      rdata[ABWR_STAT_WAKE_LOW] = q.wake_low;
    end
    if (access & ~q.rsp.ack & ~wb_req.we) begin
      next_q.rsp.dat = {24'h000000, rdata};
    end else begin
      next_q.rsp.dat = 32'h00000000;
    end

    // software writes
    if (wr && abwr_hit(wb_req.adr, ABWR_ADR_CTRL)) begin
      next_q.ctrl = wb_req.dat[7:0];
    end
    if (wr && q.cal == AB_IDLE) begin
      if (abwr_hit(wb_req.adr, ABWR_ADR_DIV_LO)) begin
        next_q.divisor[7:0] = wb_req.dat[7:0];
      end
      if (abwr_hit(wb_req.adr, ABWR_ADR_DIV_HI)) begin
        next_q.divisor[15:8] = wb_req.dat[7:0];
      end
    end

    // -----------------------------------------------------------------
    // wake on break
    // -----------------------------------------------------------------
    async_mode = ~q.ctrl[ABWR_CTRL_SYNC];
    wake_fall = 1'b0;
    if (!q.ctrl[ABWR_CTRL_WAKE] || !async_mode) begin
      next_q.wake_low = 1'b0;
    end else if (!q.wake_low) begin
      if (fall) begin
        wake_fall = 1'b1;
        next_q.wake_low = 1'b1;
      end
    end else if (rise) begin
      next_q.wake_low = 1'b0;
      next_q.ctrl[ABWR_CTRL_WAKE] = 1'b0;
    end

    // -----------------------------------------------------------------
    // baud calibration
    // -----------------------------------------------------------------
    cal_done = 1'b0;
    unique case (q.cal)
      AB_IDLE: begin
        if (q.ctrl[ABWR_CTRL_AUTOBAUD]) begin
          next_q.cal = AB_START;
        end
      end
      AB_START: begin
        // a break under wake enable is not the sync start bit
        if (fall && !q.ctrl[ABWR_CTRL_WAKE] && !q.wake_low) begin
          next_q.cal = AB_FIRST;
        end
      end
      AB_FIRST: begin
        if (rise) begin
          next_q.divisor = ABWR_DIV_RESET;
          next_q.rises = 3'h1;
          next_q.cal = AB_COUNT;
        end
      end
      AB_COUNT: begin
        if (tick) begin
          next_q.divisor = 16'(q.divisor + 16'h0001);
        end
        if (rise) begin
          next_q.rises = 3'(q.rises + 3'h1);
          if (q.rises == ABWR_LAST_RISE) begin
            cal_done = 1'b1;
            next_q.ctrl[ABWR_CTRL_AUTOBAUD] = 1'b0;
            next_q.cal = AB_IDLE;
          end
        end
      end
    endcase
    if (!q.ctrl[ABWR_CTRL_AUTOBAUD] && q.cal != AB_IDLE && !cal_done) begin
      next_q.cal = AB_IDLE;
    end

    // receive flag: a new event wins over the clearing read
    next_q.flag = wake_fall | cal_done |
      (q.flag & ~(rd & abwr_hit(wb_req.adr, ABWR_ADR_RX_DATA)));

    next_q.hold = next_q.ctrl[ABWR_CTRL_AUTOBAUD] |
      next_q.ctrl[ABWR_CTRL_WAKE];
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q.line_sync <= 3'h7;
      q.line <= 1'b1;
      q.prescale <= 9'h000;
      q.ctrl <= ABWR_CTRL_RESET;
      q.divisor <= ABWR_DIV_RESET;
      q.flag <= 1'b0;
      q.wake_low <= 1'b0;
      q.cal <= AB_IDLE;
      q.rises <= 3'h0;
      q.hold <= 1'b0;
      q.rsp <= '0;
    end else begin
      q <= next_q;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign wb_rsp = q.rsp;
  assign receive_interrupt_flag = q.flag;
  assign receiver_hold = q.hold;

endmodule
`default_nettype wire

/* hw/abwr_pkg.sv */
// Function
// - setting autobaud enable starts calibration; receiver held idle meanwhile
// - calibration times a 55h sync character with five rising edges
// - divisor counter starts at first rising edge after the start bit
// - fifth rising edge leaves count, clears autobaud enable, sets receive flag
// - both divisor bytes form one 16-bit counter during calibration
// - calibration counter runs at one eighth of the generator base clock
// - calibration clock is clk/512, clk/128 or clk/32 by speed bits
// - calibrated divisor exceeds the nominal divisor by one
// - with wake and autobaud both set, calibrate the character after the break
// - wake-on-break only in asynchronous mode; generator stops in sleep
// - while wake enable is set, reception is off and the line is watched
// - a wake event is a high-to-low transition on the receive line
// - receive flag rises at the wake event, in run and sleep alike
// - reading receive data clears the wake interrupt
// - wake enable clears itself on the rising edge ending the break
// - a non-zero character's first low time counts as the wake event
`default_nettype none
package abwr_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ABWR_ADR_CTRL = 8'h00;
  localparam logic [7:0] ABWR_ADR_DIV_LO = 8'h04;
  localparam logic [7:0] ABWR_ADR_DIV_HI = 8'h08;
  localparam logic [7:0] ABWR_ADR_RX_DATA = 8'h0C;
  localparam logic [7:0] ABWR_ADR_STATUS = 8'h10;

  // control bits of baud_control_register
  localparam int ABWR_CTRL_AUTOBAUD = 0;
  localparam int ABWR_CTRL_WAKE = 1;
  localparam int ABWR_CTRL_SYNC = 2;
  localparam int ABWR_CTRL_SIXTEEN = 3;
  localparam int ABWR_CTRL_HIGH_SPEED = 4;

  // status bits
  localparam int ABWR_STAT_FLAG = 0;
  localparam int ABWR_STAT_BUSY = 1;
  localparam int ABWR_STAT_WAKE_LOW = 2;

  // reset values
  localparam logic [7:0] ABWR_CTRL_RESET = 8'h00;
  localparam logic [15:0] ABWR_DIV_RESET = 16'h0000;
  localparam logic [7:0] ABWR_RX_DATA_IDLE = 8'h00;

  // calibration clock masks: period 512, 128, 32 clk cycles
  localparam logic [8:0] ABWR_MASK_SLOW = 9'h1FF;
  localparam logic [8:0] ABWR_MASK_MID = 9'h07F;
  localparam logic [8:0] ABWR_MASK_FAST = 9'h01F;

  // rising edges seen before the final one of the sync character
  localparam logic [2:0] ABWR_LAST_RISE = 3'h4;

  typedef enum logic [3:0] {
    AB_IDLE = 4'h1,
    AB_START = 4'h2,
    AB_FIRST = 4'h4,
    AB_COUNT = 4'h8
  } abwr_cal_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } abwr_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } abwr_wb_rsp_t;

  typedef struct packed {
    logic [2:0] line_sync;
    logic line;
    logic [8:0] prescale;
    logic [7:0] ctrl;
    logic [15:0] divisor;
    logic flag;
    logic wake_low;
    abwr_cal_t cal;
    logic [2:0] rises;
    logic hold;
    abwr_wb_rsp_t rsp;
  } abwr_state_t;

endpackage
`default_nettype wire

/* testbench/abwr_monitor.sv */
`default_nettype none
module abwr_monitor
  import abwr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus and pins
  input wire abwr_wb_req_t wb_req,
  input wire abwr_wb_rsp_t wb_rsp,
  input wire logic receive_data_line,
  input wire logic sleep_mode,
  input wire logic receive_interrupt_flag,
  input wire logic receiver_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // checks
  // ------
  logic rd_rx, wr_ctl;
  assign rd_rx = wb_rsp.ack && !wb_req.we && wb_req.adr == ABWR_ADR_RX_DATA;
  assign wr_ctl = wb_rsp.ack && wb_req.we && wb_req.sel[0] && wb_req.adr == ABWR_ADR_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack too long");
  ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack late");
  idle_data_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
    else $error("data outside ack");
  flag_clear_a: assert property (rd_rx && !receiver_hold |=> !receive_interrupt_flag)
    else $error("flag not cleared");
  flag_keep_a: assert property ($fell(receive_interrupt_flag) |-> $past(rd_rx))
    else $error("flag lost");
  flag_cause_a: assert property ($rose(receive_interrupt_flag) |-> $past(receiver_hold))
    else $error("flag without mode");
  hold_set_a: assert property (wr_ctl && wb_req.dat[1:0] != 2'h0 |=> receiver_hold)
    else $error("hold not set");
  hold_drop_a: assert property ($fell(receiver_hold) |-> receive_interrupt_flag || $past(wr_ctl))
    else $error("hold dropped");
  cover property ($rose(receive_interrupt_flag));
  cover property ($fell(receiver_hold));
  cover property (rd_rx && $past(receive_data_line));
endmodule
bind abwr_autobaud_wakeup_rx abwr_monitor u_mon (.clk(clk), .reset(reset), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .receive_data_line(receive_data_line), .sleep_mode(sleep_mode),
  .receive_interrupt_flag(receive_interrupt_flag), .receiver_hold(receiver_hold));
`default_nettype wire

/* testbench/abwr_line_tx.sv */
`default_nettype none
module abwr_line_tx (
  // clock and line
  input wire logic clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  task automatic lvl(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] b, input int t);
    lvl(1'b0, t);
    for (int i = 0; i < 8; i++) lvl(b[i], t);
    lvl(1'b1, t);
  endtask
  // all-zero break, then an idle gap
  task automatic brk(input int bits, input int t);
    lvl(1'b0, bits * t);
    lvl(1'b1, 4 * t);
  endtask
endmodule
`default_nettype wire

/* testbench/abwr_autobaud_wakeup_rx_tb.sv */
`default_nettype none
module abwr_autobaud_wakeup_rx_tb
  import abwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, sleep_mode, line, flag, hold;
  logic [31:0] rd;
  abwr_wb_req_t req;
  abwr_wb_rsp_t rsp;
  int error_cnt = 0;
  int check_count = 0;
  abwr_autobaud_wakeup_rx DUT (.clk(clk), .reset(reset), .wb_req(req), .wb_rsp(rsp),
    .receive_data_line(line), .sleep_mode(sleep_mode), .receive_interrupt_flag(flag),
    .receiver_hold(hold));
  abwr_line_tx tx (.clk(clk), .line(line));
  task automatic finish_test;
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 64);
    if (rsp.ack !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    rd = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask
  function automatic int per_of(int m);
    return m == 0 ? 512 : m == 3 ? 32 : 128;
  endfunction
  // nominal divisor for bit time t at calibration clock period p
  function automatic int ticks(int t, int p);
    return 8 * t / p - 1;
  endfunction
  // calibrated divisor reads one above the nominal value
  task automatic cal(input int e);
    logic [7:0] hi;
    int d;
    chk(32'(flag), 32'h1);
    chk(32'(hold), 32'h0);
    wb(1'b0, ABWR_ADR_DIV_HI, 8'h00);
    hi = rd[7:0];
    wb(1'b0, ABWR_ADR_DIV_LO, 8'h00);
    d = {hi, rd[7:0]};
    chk(32'(d), 32'(e + 1));
    if (e + 1 <= 255) chk(32'(hi), 32'h0);
    wb(1'b0, ABWR_ADR_RX_DATA, 8'h00);
    chk(32'(flag), 32'h0);
  endtask
  task automatic wake(input logic [7:0] c);
    wb(1'b1, ABWR_ADR_CTRL, c);
    fork
      tx.brk(13 + $urandom % 4, 40);
      begin
        repeat (20) @(posedge clk);
        chk(32'(flag), 32'(!c[2]));
        chk(32'(hold), 32'h1);
        wb(1'b0, ABWR_ADR_STATUS, 8'h00);
        chk(rd, {29'h0, !c[2], c[0], !c[2]});
      end
    join
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    int p, t;
    reset = 1'b1;
    sleep_mode = 1'b0;
    req = '0;
    rd = '0;
    void'($urandom(32'hdad4));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk(rd, 32'h0);
    end
    p = $urandom % 256;
    wb(1'b1, ABWR_ADR_DIV_LO, 8'(p));
    wb(1'b1, 8'h14, 8'hFF);
    wb(1'b0, ABWR_ADR_DIV_LO, 8'h00);
    chk(rd, 32'(p));
    wb(1'b0, 8'h14, 8'h00);
    chk(rd, 32'h0);
    for (int m = 0; m < 4; m++) begin
      p = per_of(m);
      t = p * ((m == 3) ? 33 + $urandom % 8 : 2 + $urandom % 2);
      wb(1'b1, ABWR_ADR_CTRL, 8'(1 + m * 8));
      chk(32'(hold), 32'h1);
      tx.frame(8'h55, t);
      cal(ticks(t, p));
      wb(1'b0, ABWR_ADR_CTRL, 8'h00);
      chk(rd, 32'(m * 8));
    end
    sleep_mode <= 1'($urandom);
    wake(8'h02);
    chk(32'(hold), 32'h0);
    wb(1'b0, ABWR_ADR_CTRL, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, ABWR_ADR_RX_DATA, 8'h00);
    chk(32'(flag), 32'h0);
    sleep_mode <= 1'b0;
    wake(8'h1B);
    chk(32'(hold), 32'h1);
    wb(1'b0, ABWR_ADR_RX_DATA, 8'h00);
    tx.frame(8'h55, 32 * 34);
    cal(ticks(32 * 34, 32));
    wake(8'h06);
    wb(1'b1, ABWR_ADR_CTRL, 8'h00);
    chk(32'(flag), 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
